// File: esarc_pkg.sv
// Summary of operation
// - Receive align bit rising edge brings receive store pointers to half-frame separation.
// - Transmit align bit rising edge brings transmit store pointers to half-frame separation.
// - Align with separation already half a frame or more leaves pointers alone.
// - Align with separation under half a frame repositions pointers; data may break.
// - Five-bit channel select picks the receive channel copied to the monitor register.
// - Source select zero: formatter runs from the line clock pin, fallback stays active.
// - Source select one: formatter runs from the recovered receive clock.
// - Receive store reset bit rising edge forces receive store depth to one frame.
// - Receive data in the store during its reset is discarded.
// - Transmit store reset bit rising edge forces transmit store depth to one frame.
// - Transmit data in the store during its reset is discarded.
// - Fallback enabled and line clock stopped: formatter switches to recovered receive clock.
package esarc_pkg;
  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] ALIGN_MON_ADDR = 8'hAA;
  localparam logic [7:0] CLK_RST_ADDR = 8'h1D;
  localparam logic [7:0] ALIGN_MON_RESET = 8'h00;
  localparam logic [7:0] CLK_RST_RESET = 8'h00;
  localparam logic [7:0] ALIGN_MON_MASK = 8'h7F;
  localparam logic [7:0] CLK_RST_MASK = 8'h07;
  localparam int RX_ALIGN_BIT = 6;
  localparam int TX_ALIGN_BIT = 5;
  localparam int CHAN_SEL_MSB = 4;
  localparam int TX_CLK_SRC_BIT = 2;
  localparam int RX_RESET_BIT = 1;
  localparam int TX_RESET_BIT = 0;
  // ****************************************************************
  // Store geometry and timing
  // ****************************************************************
  localparam int PTR_W = 6;
  localparam logic [PTR_W-1:0] FRAME_BYTES = 6'h20;
  localparam logic [PTR_W-1:0] HALF_FRAME_BYTES = 6'h10;
  localparam int REF_CLK_MHZ = 25;
  localparam int LOSS_TIME_NS = 1000;
  localparam int LOSS_CYCLES = (LOSS_TIME_NS * REF_CLK_MHZ) / 1000;
  localparam int LOSS_CNT_W = 8;

  typedef struct packed {
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
  } esarc_ptrs_t;

  typedef struct packed {
    logic load;
    logic [PTR_W-1:0] rd_ptr;
    logic flush;
  } esarc_load_t;

  typedef struct packed {
    logic valid;
    logic [4:0] chan;
    logic [7:0] data;
  } esarc_chan_t;
endpackage

// File: esarc_ctrl.sv
`timescale 1ns/1ps
// ****************************************************************
// Per-store command catcher and pointer loader
// ****************************************************************
module esarc_store_ctrl (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic align_bit,
  input wire logic reset_bit,
  input wire logic bp_clk,
  input wire esarc_pkg::esarc_ptrs_t ptrs,
  output esarc_pkg::esarc_load_t ld
);
  import esarc_pkg::*;
  // Command edge state, backplane sampling and the load register
  logic align_q_ff, reset_q_ff, pend_align_ff, pend_reset_ff;
  logic bp_s1_ff, bp_s2_ff, bp_s3_ff;
  logic bp_edge, align_edge, reset_edge, serve;
  logic [PTR_W-1:0] sep;
  esarc_load_t ld_ff;

  // Edge strobes and the serve slot
  assign bp_edge = bp_s2_ff & ~bp_s3_ff;
  assign align_edge = align_bit & ~align_q_ff;
  assign reset_edge = reset_bit & ~reset_q_ff;
  assign serve = bp_edge & (pend_align_ff | pend_reset_ff);
  // Pointer separation, modulo the store size
  assign sep = ptrs.wr_ptr - ptrs.rd_ptr;
  assign ld = ld_ff;

  // Backplane clock synchroniser, edge taken from the second stage
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bp_s1_ff <= 1'b0;
      bp_s2_ff <= 1'b0;
      bp_s3_ff <= 1'b0;
    end else begin
      bp_s1_ff <= bp_clk;
      bp_s2_ff <= bp_s1_ff;
      bp_s3_ff <= bp_s2_ff;
    end
  end

  // Command edge detection, each edge held pending once; new edge beats serve
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      align_q_ff <= 1'b0;
      reset_q_ff <= 1'b0;
      pend_align_ff <= 1'b0;
      pend_reset_ff <= 1'b0;
    end else begin
      align_q_ff <= align_bit;
      reset_q_ff <= reset_bit;
      pend_align_ff <= align_edge | (pend_align_ff & ~serve);
      pend_reset_ff <= reset_edge | (pend_reset_ff & ~serve);
    end
  end

  // Pointer load on a backplane clock edge; reset outranks align
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ld_ff <= '0;
    end else begin
      ld_ff <= '0;
      if (serve && pend_reset_ff) begin
        ld_ff.load <= 1'b1;
        ld_ff.rd_ptr <= ptrs.wr_ptr - FRAME_BYTES;
        ld_ff.flush <= 1'b1;
      end else if (serve && (sep < HALF_FRAME_BYTES)) begin
        ld_ff.load <= 1'b1;
        ld_ff.rd_ptr <= ptrs.wr_ptr - HALF_FRAME_BYTES;
      end
    end
  end
endmodule

// ****************************************************************
// Top: control registers, store commands, clock source, monitor
// ****************************************************************
module esarc_ctrl #(
  parameter int LOSS_LIMIT = esarc_pkg::LOSS_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata,
  input wire logic rx_backplane_clock,
  input wire logic tx_backplane_clock,
  input wire logic tx_line_clock,
  input wire logic tx_clock_loss_fallback,
  input wire esarc_pkg::esarc_ptrs_t rx_ptrs,
  input wire esarc_pkg::esarc_ptrs_t tx_ptrs,
  output esarc_pkg::esarc_load_t rx_load,
  output esarc_pkg::esarc_load_t tx_load,
  input wire esarc_pkg::esarc_chan_t rx_chan_in,
  output logic [7:0] rx_channel_monitor_reg,
  output logic tx_use_recovered_clk,
  output logic tx_line_clock_lost
);
  import esarc_pkg::*;
  // Control registers, read and monitor holding, pin samplers
  logic [7:0] store_align_and_rx_monitor_ctrl_ff;
  logic [7:0] tx_clock_and_store_reset_ctrl_ff;
  logic [7:0] rdata_ff, mon_ff;
  logic tc_s1_ff, tc_s2_ff, tc_s3_ff, lost_ff, use_rcv_ff;
  logic fb_s1_ff, fb_s2_ff;
  logic [LOSS_CNT_W-1:0] loss_cnt_ff;
  logic [4:0] chan_sel;

  // Channel select field and output drives
  assign chan_sel = store_align_and_rx_monitor_ctrl_ff[CHAN_SEL_MSB:0];
  assign bus_rdata = rdata_ff;
  assign rx_channel_monitor_reg = mon_ff;
  assign tx_use_recovered_clk = use_rcv_ff;
  assign tx_line_clock_lost = lost_ff;

  // Register writes; unassigned bits are held at zero
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      store_align_and_rx_monitor_ctrl_ff <= ALIGN_MON_RESET;
      tx_clock_and_store_reset_ctrl_ff <= CLK_RST_RESET;
    end else if (bus_wr) begin
      if (bus_addr == ALIGN_MON_ADDR) begin
        store_align_and_rx_monitor_ctrl_ff <= bus_wdata & ALIGN_MON_MASK;
      end
      if (bus_addr == CLK_RST_ADDR) begin
        tx_clock_and_store_reset_ctrl_ff <= bus_wdata & CLK_RST_MASK;
      end
    end
  end

  // Register reads; other addresses read zero
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= 8'h00;
    end else if (bus_rd) begin
      if (bus_addr == ALIGN_MON_ADDR) begin
        rdata_ff <= store_align_and_rx_monitor_ctrl_ff;
      end else if (bus_addr == CLK_RST_ADDR) begin
        rdata_ff <= tx_clock_and_store_reset_ctrl_ff;
      end else begin
        rdata_ff <= 8'h00;
      end
    end
  end

  // Receive channel monitor copy
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mon_ff <= 8'h00;
    end else if (rx_chan_in.valid && (rx_chan_in.chan == chan_sel)) begin
      mon_ff <= rx_chan_in.data;
    end
  end

  // Line clock and fallback enable synchronisers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tc_s1_ff <= 1'b0;
      tc_s2_ff <= 1'b0;
      tc_s3_ff <= 1'b0;
      fb_s1_ff <= 1'b0;
      fb_s2_ff <= 1'b0;
    end else begin
      tc_s1_ff <= tx_line_clock;
      tc_s2_ff <= tc_s1_ff;
      tc_s3_ff <= tc_s2_ff;
      fb_s1_ff <= tx_clock_loss_fallback;
      fb_s2_ff <= fb_s1_ff;
    end
  end

  // Line clock loss watchdog: no edge for the loss time
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      loss_cnt_ff <= '0;
      lost_ff <= 1'b0;
    end else if (tc_s2_ff != tc_s3_ff) begin
      loss_cnt_ff <= '0;
      lost_ff <= 1'b0;
    end else if (loss_cnt_ff == LOSS_CNT_W'(LOSS_LIMIT)) begin
      lost_ff <= 1'b1;
    end else begin
      loss_cnt_ff <= loss_cnt_ff + 1'b1;
    end
  end

  // Formatter clock source choice
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      use_rcv_ff <= 1'b0;
    end else begin
      use_rcv_ff <= tx_clock_and_store_reset_ctrl_ff[TX_CLK_SRC_BIT]
                    | (fb_s2_ff & lost_ff);
    end
  end

  // Receive store command path, served on the receive backplane clock
  esarc_store_ctrl u_rx (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .align_bit(store_align_and_rx_monitor_ctrl_ff[RX_ALIGN_BIT]),
    .reset_bit(tx_clock_and_store_reset_ctrl_ff[RX_RESET_BIT]),
    .bp_clk(rx_backplane_clock),
    .ptrs(rx_ptrs),
    .ld(rx_load)
  );

  // Transmit store command path, served on the transmit backplane clock
  esarc_store_ctrl u_tx (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .align_bit(store_align_and_rx_monitor_ctrl_ff[TX_ALIGN_BIT]),
    .reset_bit(tx_clock_and_store_reset_ctrl_ff[TX_RESET_BIT]),
    .bp_clk(tx_backplane_clock),
    .ptrs(tx_ptrs),
    .ld(tx_load)
  );
endmodule

// File: esarc_ctrl_monitor.sv
`timescale 1ns/1ps
// ****
// Port checker for store loads and clock source
// ****
module esarc_ctrl_monitor (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic tx_clock_loss_fallback,
  input wire esarc_pkg::esarc_ptrs_t rx_ptrs,
  input wire esarc_pkg::esarc_ptrs_t tx_ptrs,
  input wire esarc_pkg::esarc_load_t rx_load,
  input wire esarc_pkg::esarc_load_t tx_load,
  input wire esarc_pkg::esarc_chan_t rx_chan_in,
  input wire logic [7:0] rx_channel_monitor_reg,
  input wire logic tx_use_recovered_clk,
  input wire logic tx_line_clock_lost
);
  import esarc_pkg::*;
  // All checks on the one clock
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_rx_load_pulse: assert property (rx_load.load |=> !rx_load.load) else $error("rx load too long");
  a_tx_load_pulse: assert property (tx_load.load |=> !tx_load.load) else $error("tx load too long");
  a_rx_align_half: assert property (rx_load.load && !rx_load.flush |->
    rx_load.rd_ptr == $past(rx_ptrs.wr_ptr) - 6'h10) else $error("rx align pointer");
  a_tx_align_half: assert property (tx_load.load && !tx_load.flush |->
    tx_load.rd_ptr == $past(tx_ptrs.wr_ptr) - 6'h10) else $error("tx align pointer");
  a_rx_align_need: assert property (rx_load.load && !rx_load.flush |->
    ($past(rx_ptrs.wr_ptr) - $past(rx_ptrs.rd_ptr)) < HALF_FRAME_BYTES) else $error("rx align not needed");
  a_tx_align_need: assert property (tx_load.load && !tx_load.flush |->
    ($past(tx_ptrs.wr_ptr) - $past(tx_ptrs.rd_ptr)) < HALF_FRAME_BYTES) else $error("tx align not needed");
  a_rx_reset_frame: assert property (rx_load.flush |-> rx_load.load &&
    rx_load.rd_ptr == $past(rx_ptrs.wr_ptr) - 6'h20) else $error("rx reset depth");
  a_tx_reset_frame: assert property (tx_load.flush |-> tx_load.load &&
    tx_load.rd_ptr == $past(tx_ptrs.wr_ptr) - 6'h20) else $error("tx reset depth");
  a_mon_copy_src: assert property ($changed(rx_channel_monitor_reg) |-> $past(rx_chan_in.valid) &&
    rx_channel_monitor_reg == $past(rx_chan_in.data)) else $error("monitor copy");
  a_fallback_switch: assert property ((tx_line_clock_lost && tx_clock_loss_fallback) [*4]
    |-> tx_use_recovered_clk) else $error("no fallback");
endmodule
bind esarc_ctrl esarc_ctrl_monitor i_mon (.ref_clk, .rst_n, .tx_clock_loss_fallback, .rx_ptrs, .tx_ptrs,
  .rx_load, .tx_load, .rx_chan_in, .rx_channel_monitor_reg, .tx_use_recovered_clk, .tx_line_clock_lost);

// File: esarc_host_model.sv
`timescale 1ns/1ps
// ****
// Host on the parallel control port
// ****
module esarc_host_model (
  input wire logic ref_clk,
  output logic [7:0] bus_addr,
  output logic [7:0] bus_wdata,
  output logic bus_wr,
  output logic bus_rd,
  input wire logic [7:0] bus_rdata
);
  // Idle bus at time zero
  initial begin
    bus_addr = 8'h00;
    bus_wdata = 8'h00;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
  end
  // One write; data scrambled once released
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge ref_clk);
    bus_wr <= 1'b0;
    bus_wdata <= ~d;
  endtask
  // One read; result taken once settled
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge ref_clk);
    bus_rd <= 1'b0;
    repeat (2) @(posedge ref_clk);
    d = bus_rdata;
  endtask
  // Command bit up, then back down
  task automatic pulse(input logic [7:0] a, input logic [7:0] m);
    wr(a, m);
    wr(a, 8'h00);
  endtask
endmodule

// File: tb.sv
`timescale 1ns/1ps
// ****
// Bench for store commands and clock source
// ****
module tb;
  import esarc_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] bus_addr, bus_wdata, bus_rdata, rx_channel_monitor_reg, rdv;
  logic bus_wr, bus_rd, tx_line_clock_lost, tx_use_recovered_clk;
  logic tx_clock_loss_fallback = 1'b0;
  logic tx_line_clock = 1'b0;
  logic run = 1'b1;
  logic [2:0] bp = 3'h0;
  esarc_ptrs_t rx_ptrs = '0;
  esarc_ptrs_t tx_ptrs = '0;
  esarc_load_t rx_load, tx_load, got;
  esarc_chan_t rx_chan_in = '0;
  int mismatches = 0;
  int total_checks = 0;
  always #20 ref_clk = ~ref_clk;
  // Backplane clocks run from the start; line clock can be stopped
  always @(posedge ref_clk) begin
    bp <= bp + 3'h1;
    if (run) tx_line_clock <= ~tx_line_clock;
  end
  esarc_host_model i_host (.ref_clk, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata);
  esarc_ctrl i_dut (.ref_clk, .rst_n, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata,
    .rx_backplane_clock(bp[1]), .tx_backplane_clock(bp[2]), .tx_line_clock, .tx_clock_loss_fallback,
    .rx_ptrs, .tx_ptrs, .rx_load, .tx_load, .rx_chan_in, .rx_channel_monitor_reg, .tx_use_recovered_clk,
    .tx_line_clock_lost);
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Pulse a command bit and catch the load it produces
  task automatic cmd(input logic [7:0] a, input logic [7:0] m, input logic rx, input esarc_ptrs_t p,
    input esarc_load_t e);
    got = '0;
    rx_ptrs <= p;
    tx_ptrs <= p;
    fork
      i_host.pulse(a, m);
      repeat (24) begin
        @(posedge ref_clk);
        if ((rx ? rx_load.load : tx_load.load) === 1'b1) got = rx ? rx_load : tx_load;
      end
    join
    chk(got, e);
  endtask
  task automatic t_regs();
    i_host.rd(ALIGN_MON_ADDR, rdv);
    chk(rdv, ALIGN_MON_RESET);
    i_host.wr(ALIGN_MON_ADDR, 8'h9F);
    i_host.rd(ALIGN_MON_ADDR, rdv);
    chk(rdv, 8'h9F & ALIGN_MON_MASK);
    i_host.wr(8'h10, 8'h55);
    i_host.rd(8'h10, rdv);
    chk(rdv, 8'h00);
  endtask
  task automatic t_mon(input logic [4:0] s, input logic [7:0] d);
    i_host.wr(ALIGN_MON_ADDR, {3'h0, s});
    @(posedge ref_clk);
    rx_chan_in <= '{1'b1, s, d};
    @(posedge ref_clk);
    rx_chan_in <= '{1'b1, s ^ 5'h01, ~d};
    @(posedge ref_clk);
    rx_chan_in <= '{1'b0, s, d};
    repeat (2) @(posedge ref_clk);
    chk(rx_channel_monitor_reg, d);
  endtask
  task automatic t_align();
    cmd(ALIGN_MON_ADDR, 8'h40, 1'b1, '{6'h05, 6'h00}, {1'b1, 6'h05 - HALF_FRAME_BYTES, 1'b0});
    cmd(ALIGN_MON_ADDR, 8'h40, 1'b1, '{6'h20, 6'h10}, 8'h00);
    cmd(ALIGN_MON_ADDR, 8'h20, 1'b0, '{6'h02, 6'h01}, {1'b1, 6'h02 - HALF_FRAME_BYTES, 1'b0});
  endtask
  // Align bit written high again without a clear: no further align
  task automatic t_hold();
    i_host.wr(ALIGN_MON_ADDR, 8'h40);
    repeat (24) @(posedge ref_clk);
    cmd(ALIGN_MON_ADDR, 8'h40, 1'b1, '{6'h03, 6'h00}, 8'h00);
  endtask
  task automatic t_reset();
    cmd(CLK_RST_ADDR, 8'h02, 1'b1, '{6'h07, 6'h01}, {1'b1, 6'h07 - FRAME_BYTES, 1'b1});
    cmd(CLK_RST_ADDR, 8'h01, 1'b0, '{6'h30, 6'h2F}, {1'b1, 6'h30 - FRAME_BYTES, 1'b1});
  endtask
  task automatic t_clk();
    i_host.wr(CLK_RST_ADDR, 8'h04);
    i_host.rd(CLK_RST_ADDR, rdv);
    chk(rdv, 8'h04);
    repeat (4) @(posedge ref_clk);
    chk({7'h00, tx_use_recovered_clk}, 8'h01);
    i_host.wr(CLK_RST_ADDR, 8'h00);
    repeat (4) @(posedge ref_clk);
    chk({7'h00, tx_use_recovered_clk}, 8'h00);
    run <= 1'b0;
    tx_clock_loss_fallback <= 1'b1;
    repeat (40) @(posedge ref_clk);
    chk({6'h00, tx_line_clock_lost, tx_use_recovered_clk}, 8'h03);
    run <= 1'b1;
    repeat (8) @(posedge ref_clk);
    chk({6'h00, tx_line_clock_lost, tx_use_recovered_clk}, 8'h00);
  endtask
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    t_regs();
    t_mon(5'h1F, 8'h5A);
    t_mon(5'h00, 8'hC3);
    t_align();
    t_hold();
    t_reset();
    t_clk();
    report_and_stop();
  end
  // Watchdog well past the expected run
  initial begin
    #100000;
    mismatches++;
    report_and_stop();
  end
endmodule
